// ==== srrc_core_model.sv ====
// Purpose: core, interrupt controller and reset source beside srrc_top
// Assumes: requests change just after a rising edge of aclk
// Notes: the bench drives it through its tasks
`timescale 1ns/10ps
module srrc_core_model
    import srrc_pkg::*;
(
    // clock
    input wire logic aclk,
    // requests into the controller
    output logic halt_exec,
    output logic stop_exec,
    output logic reset_pin_n,
    output logic [7:0] irq_event
);
    initial begin
        halt_exec = 1'b0;
        stop_exec = 1'b0;
        reset_pin_n = 1'b1;
        irq_event = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // kind 0 halt, 1 stop, anything else only the request event
    task automatic pulse(input int kind, input logic [7:0] ev);
        @(posedge aclk);
        halt_exec <= (kind == 0);
        stop_exec <= (kind == 1);
        irq_event <= ev;
        @(posedge aclk);
        halt_exec <= 1'b0;
        stop_exec <= 1'b0;
        irq_event <= 8'h00;
    endtask
    // held for exactly the minimum width, SRRC_PIN_LOW_CYC cycles, so every pin reset is a valid one
    task automatic pin_reset();
        @(posedge aclk);
        reset_pin_n <= 1'b0;
        repeat (SRRC_PIN_LOW_CYC) @(posedge aclk);
        reset_pin_n <= 1'b1;
    endtask
endmodule // srrc_core_model

// ==== srrc_pkg.sv ====
// Purpose: constants and carriers for the standby release and reset controller
// Assumes: one 50 MHz clock stands in for the main oscillator; 8-bit register values
// Notes: register map is on AXI4-Lite, one 32-bit word per register
package srrc_pkg;
    localparam logic [7:0] SRRC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SRRC_OFF_SETTLE = 8'h04;
    localparam logic [7:0] SRRC_OFF_STATUS = 8'h08;
    localparam logic [7:0] SRRC_OFF_IRQ = 8'h0c;
    localparam logic [7:0] SRRC_OFF_PORT = 8'h10;
    localparam logic [7:0] SRRC_RST_STATUS_WORD = 8'h02;
    localparam logic [7:0] SRRC_RST_PORT = 8'h00;
    localparam logic [7:0] SRRC_RST_SETTLE = 8'h04;
    localparam logic [7:0] SRRC_RST_REQ = 8'h00;
    localparam logic [7:0] SRRC_RST_MASK = 8'hff;
    localparam logic [15:0] SRRC_RESET_VECTOR = 16'h0000;
    localparam int SRRC_EXP_W0 = 12;
    localparam int SRRC_EXP_W1 = 14;
    localparam int SRRC_EXP_W2 = 15;
    localparam int SRRC_EXP_W3 = 16;
    localparam int SRRC_EXP_W4 = 17;
    localparam int SRRC_CLK_MHZ = 50;
    localparam int SRRC_PIN_LOW_NS = 10000;
    localparam int SRRC_PIN_LOW_CYC = (SRRC_PIN_LOW_NS * SRRC_CLK_MHZ + 999) / 1000;
    localparam logic [1:0] SRRC_RESP_OKAY = 2'b00;
    localparam logic [1:0] SRRC_RESP_SLVERR = 2'b10;

    typedef enum {SRRC_RESET, SRRC_SETTLE, SRRC_RUN, SRRC_HALT, SRRC_STOP} srrc_mode_e;

    // what the controller tells the core about a wake decision
    typedef struct packed {
        logic vector_go;
        logic resume_go;
        logic reset_go;
    } srrc_wake_s;

    // fixed levels of the expansion bus during stop
    typedef struct packed {
        logic low_lines_oe_n;
        logic latch_strobe;
        logic rd_strobe;
        logic wr_strobe;
        logic wait_oe_n;
    } srrc_bus_s;
endpackage

// ==== srrc_top.sv ====
// Purpose: standby entry/release, settling wait and reset sequencing
// Assumes: aclk is the main oscillator clock; wake requests come in synchronous
// Notes: long waits are parameters so a bench can shorten them
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module srrc_top
    import srrc_pkg::*;
#(
    parameter int unsigned SETTLE_SCALE = 0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // reset sources
    input wire logic reset_pin_n,
    input wire logic wdt_overflow,
    // core side
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic on_subsystem_clk,
    input wire logic global_accept_flag,
    input wire logic in_service_level_flag,
    input wire logic nmi_req,
    input wire logic [7:0] irq_event,
    output srrc_wake_s wake,
    output logic [15:0] pc_load,
    output logic cpu_clk_en,
    output logic main_osc_en,
    // peripheral gating
    output logic timer16_run,
    output logic wdt_run,
    output logic adc_run,
    output logic timer8_ext_only,
    output logic watch_sub_only,
    output logic serial_ext_clk_only,
    output logic uart_freeze,
    // pins
    output logic crystal_out_pullup,
    output logic clock_out_force_low,
    output logic tone_out_force_low,
    output logic port_hold,
    output logic pins_hiz,
    output logic [7:0] port_latch,
    output srrc_bus_s bus_stop,
    output logic upper_bus_hold
);

    //////////////////////////////////////////////////////////////////////////
    // reset pin synchroniser and qualification
    logic [2:0] pin_sync_ff;
    logic pin_low_ff;
    logic ext_reset;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_ff <= 3'h7;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], reset_pin_n};
        end
    end

    // set or clear pin_low_ff only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_low_ff <= 1'b0;
        end else if (!pin_sync_ff[1] && !pin_sync_ff[2]) begin
            pin_low_ff <= 1'b1;
        end else if (pin_sync_ff[1] && pin_sync_ff[2]) begin
            pin_low_ff <= 1'b0;
        end
    end

    // reset is applied as soon as the pin reads low; the 10 us hold is the source's duty
    assign ext_reset = pin_low_ff;

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] settle_wait_select_ff;
    logic [7:0] request_masked_flag_ff;
    logic [7:0] low_rank_flag_ff;
    logic [7:0] req_flag_ff;
    logic [7:0] port_latch_ff;
    logic [7:0] status_word_ff;
    logic [3:0] wr_strb_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] wr_data_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic wr_go;
    srrc_mode_e mode_ff;
    logic any_reset;

    assign any_reset = ext_reset | wdt_overflow;

    assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 32'h0000_0000;
            wr_strb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SRRC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                wr_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wr_data_ff <= s_axi_wdata;
                wr_strb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr_ff == SRRC_OFF_STATUS || wr_addr_ff > SRRC_OFF_PORT) ?
                               SRRC_RESP_SLVERR : SRRC_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // ctrl word: [7:0] mask flags, [15:8] rank flags; irq word write-one-clears
    always_ff @(posedge aclk) begin
        if (!aresetn || any_reset) begin
            settle_wait_select_ff <= SRRC_RST_SETTLE;
            request_masked_flag_ff <= SRRC_RST_MASK;
            low_rank_flag_ff <= SRRC_RST_MASK;
            port_latch_ff <= SRRC_RST_PORT;
            status_word_ff <= SRRC_RST_STATUS_WORD;
        end else if (wr_go) begin
            case (wr_addr_ff)
                SRRC_OFF_CTRL: begin
                    if (wr_strb_ff[0]) request_masked_flag_ff <= wr_data_ff[7:0];
                    if (wr_strb_ff[1]) low_rank_flag_ff <= wr_data_ff[15:8];
                end
                SRRC_OFF_SETTLE: settle_wait_select_ff <= {5'h00, wr_data_ff[2:0]};
                SRRC_OFF_PORT: if (mode_ff != SRRC_STOP) port_latch_ff <= wr_data_ff[7:0];
                default: status_word_ff <= status_word_ff;
            endcase
        end
    end

    // request flags: a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || any_reset) begin
            req_flag_ff <= SRRC_RST_REQ;
        end else begin
            req_flag_ff <= (req_flag_ff & ~((wr_go && wr_addr_ff == SRRC_OFF_IRQ) ? wr_data_ff[7:0] : 8'h00))
                           | irq_event;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SRRC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= SRRC_RESP_OKAY;
            case (s_axi_araddr)
                SRRC_OFF_CTRL: s_axi_rdata <= {16'h0000, low_rank_flag_ff, request_masked_flag_ff};
                SRRC_OFF_SETTLE: s_axi_rdata <= {24'h000000, settle_wait_select_ff};
                SRRC_OFF_STATUS: s_axi_rdata <= {16'h0000, status_word_ff, 5'h00, 3'(mode_ff)};
                SRRC_OFF_IRQ: s_axi_rdata <= {24'h000000, req_flag_ff};
                SRRC_OFF_PORT: s_axi_rdata <= {24'h000000, port_latch_ff};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= SRRC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    //////////////////////////////////////////////////////////////////////////
    // wake decision
    logic [7:0] pend;
    logic any_pend;
    logic go_vector;

    assign pend = req_flag_ff & ~request_masked_flag_ff;
    assign any_pend = |pend;
    // high rank pending, or only low rank with a free service level
    assign go_vector = global_accept_flag &&
                       ((|(pend & ~low_rank_flag_ff)) || in_service_level_flag);

    //////////////////////////////////////////////////////////////////////////
    // settling counter
    logic [17:0] settle_cnt_ff;
    logic [17:0] settle_limit;
    logic settle_done;
    logic settle_for_reset_ff;
    logic settle_vector_ff;

    always_comb begin
        case (settle_wait_select_ff[2:0])
            3'h0: settle_limit = 18'(1) << SRRC_EXP_W0;
            3'h1: settle_limit = 18'(1) << SRRC_EXP_W1;
            3'h2: settle_limit = 18'(1) << SRRC_EXP_W2;
            3'h3: settle_limit = 18'(1) << SRRC_EXP_W3;
            default: settle_limit = 18'(1) << SRRC_EXP_W4;
        endcase
        if (settle_for_reset_ff) begin
            settle_limit = 18'(1) << SRRC_EXP_W4;
        end
        settle_limit = settle_limit >> SETTLE_SCALE;
    end
    assign settle_done = (settle_cnt_ff + 18'h00001) >= settle_limit;

    always_ff @(posedge aclk) begin
        if (!aresetn || mode_ff != SRRC_SETTLE) begin
            settle_cnt_ff <= 18'h00000;
        end else begin
            settle_cnt_ff <= settle_cnt_ff + 18'h00001;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // mode sequencer
    logic from_stop_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff <= SRRC_RESET;
            settle_for_reset_ff <= 1'b1;
            settle_vector_ff <= 1'b0;
            from_stop_ff <= 1'b0;
            wake <= '0;
        end else begin
            wake <= '0;
            case (mode_ff)
                SRRC_RESET: begin
                    if (!any_reset) begin
                        mode_ff <= SRRC_SETTLE;
                        settle_for_reset_ff <= 1'b1;
                    end
                end
                SRRC_SETTLE: begin
                    if (ext_reset && !settle_for_reset_ff) begin
                        mode_ff <= SRRC_RESET;
                    end else if (settle_done) begin
                        mode_ff <= SRRC_RUN;
                        from_stop_ff <= 1'b0;
                        if (settle_for_reset_ff) begin
                            wake.reset_go <= 1'b1;
                        end else if (settle_vector_ff) begin
                            wake.vector_go <= 1'b1;
                        end else begin
                            wake.resume_go <= 1'b1;
                        end
                    end
                end
                SRRC_RUN: begin
                    if (any_reset) begin
                        mode_ff <= SRRC_RESET;
                    end else if (stop_exec && !on_subsystem_clk) begin
                        if (any_pend) begin
                            mode_ff <= SRRC_SETTLE;
                            settle_for_reset_ff <= 1'b0;
                            settle_vector_ff <= go_vector;
                        end else begin
                            mode_ff <= SRRC_STOP;
                            from_stop_ff <= 1'b1;
                        end
                    end else if (halt_exec) begin
                        mode_ff <= SRRC_HALT;
                    end
                end
                SRRC_HALT: begin
                    if (any_reset) begin
                        mode_ff <= SRRC_RESET;
                    end else if (nmi_req) begin
                        mode_ff <= SRRC_RUN;
                        wake.vector_go <= 1'b1;
                    end else if (any_pend) begin
                        mode_ff <= SRRC_RUN;
                        wake.vector_go <= go_vector;
                        wake.resume_go <= !go_vector;
                    end
                end
                SRRC_STOP: begin
                    if (ext_reset) begin
                        mode_ff <= SRRC_SETTLE;
                        settle_for_reset_ff <= 1'b1;
                    end else if (any_pend) begin
                        mode_ff <= SRRC_SETTLE;
                        settle_for_reset_ff <= 1'b0;
                        settle_vector_ff <= go_vector;
                    end
                end
                default: mode_ff <= SRRC_RESET;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    logic stopped;
    logic reset_phase;

    assign stopped = (mode_ff == SRRC_STOP);
    assign reset_phase = (mode_ff == SRRC_RESET) || (mode_ff == SRRC_SETTLE && settle_for_reset_ff);

    assign pc_load = SRRC_RESET_VECTOR;
    assign cpu_clk_en = (mode_ff == SRRC_RUN);
    assign main_osc_en = !stopped && mode_ff != SRRC_RESET;
    assign timer16_run = !stopped && !reset_phase;
    assign wdt_run = !stopped && !reset_phase;
    assign adc_run = !stopped && !reset_phase;
    assign timer8_ext_only = stopped;
    assign watch_sub_only = stopped;
    assign serial_ext_clk_only = stopped;
    assign uart_freeze = stopped;
    assign crystal_out_pullup = stopped;
    assign clock_out_force_low = stopped;
    assign tone_out_force_low = stopped;
    assign port_hold = stopped || from_stop_ff;
    assign pins_hiz = reset_phase;
    assign port_latch = port_latch_ff;
    assign upper_bus_hold = stopped;
    assign bus_stop = stopped ? srrc_bus_s'{1'b1, 1'b0, 1'b1, 1'b1, 1'b1} : '0;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb_chk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_halt_mask;
        (mode_ff == SRRC_HALT && !any_reset && !nmi_req && !any_pend) |=> mode_ff == SRRC_HALT;
    endproperty
    a_halt_mask: assert property (p_halt_mask) else $error("masked request left halt");
    property p_nmi;
        (mode_ff == SRRC_HALT && nmi_req && !any_reset) |=> wake.vector_go && mode_ff == SRRC_RUN;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi did not vector");
    property p_halt_reset;
        (mode_ff == SRRC_HALT && any_reset) |=> mode_ff == SRRC_RESET;
    endproperty
    a_halt_reset: assert property (p_halt_reset) else $error("reset did not end halt");
    property p_sub_no_stop;
        (mode_ff == SRRC_RUN && on_subsystem_clk) |=> mode_ff != SRRC_STOP;
    endproperty
    a_sub_no_stop: assert property (p_sub_no_stop) else $error("stop entered on sub clock");
    property p_stop_pins;
        stopped |-> crystal_out_pullup && clock_out_force_low && tone_out_force_low && !main_osc_en;
    endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("stop pin state wrong");
    property p_pending_stop;
        (mode_ff == SRRC_RUN && stop_exec && !on_subsystem_clk && any_pend && !any_reset)
            |=> mode_ff == SRRC_SETTLE;
    endproperty
    a_pending_stop: assert property (p_pending_stop) else $error("pending stop not released");
    property p_reset_hiz;
        (mode_ff == SRRC_RESET) |-> pins_hiz && !cpu_clk_en;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pins not floated in reset");
    property p_settle_len;
        wake.reset_go |-> $past(settle_cnt_ff) == (settle_limit - 18'h00001);
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle wait length wrong");
    property p_stop_bus;
        stopped |-> bus_stop.rd_strobe && bus_stop.wr_strobe && !bus_stop.latch_strobe && upper_bus_hold;
    endproperty
    a_stop_bus: assert property (p_stop_bus) else $error("stop bus levels wrong");

    c_halt_vector: cover property (@(posedge aclk) mode_ff == SRRC_HALT ##1 wake.vector_go);
    c_stop_wake: cover property (@(posedge aclk) mode_ff == SRRC_STOP ##1 mode_ff == SRRC_SETTLE);
    c_reset_run: cover property (@(posedge aclk) wake.reset_go);

endmodule // srrc_top

// ==== test_standby_release_and_reset_control.sv ====
// Purpose: self-checking bench for srrc_top
// Assumes: SETTLE_SCALE 8, so the reset wait is 512 cycles and code 0 gives 16
// Notes: wake pulses are counted in the background and compared per scenario
`timescale 1ns/10ps
module test_standby_release_and_reset_control
    import srrc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic wdt_ov = 1'b0, on_sub = 1'b0, accept = 1'b0, in_svc = 1'b0, nmi = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic halt_exec, stop_exec, reset_pin_n, cpu_clk_en, main_osc_en, pins_hiz;
    logic crystal_out_pullup, clock_out_force_low, tone_out_force_low;
    logic [7:0] irq_event;
    logic [15:0] pc_load;
    srrc_wake_s wake;
    srrc_bus_s bus_stop;
    int num_errors = 0, comparisons = 0, cyc = 0, t0 = 0, rst_at = 0;
    int nvec = 0, nres = 0, nwk = 0, nrst = 0;
    // rows: mask, rank, accept, in-service, outcome (0 resume, 1 vector, 2 hold)
    localparam logic [5:0] TBL [6] = '{6'b000000, 6'b001001, 6'b010100, 6'b011000, 6'b011101, 6'b101110};

    srrc_top #(.SETTLE_SCALE(8)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .reset_pin_n, .wdt_overflow(wdt_ov), .halt_exec, .stop_exec,
        .on_subsystem_clk(on_sub), .global_accept_flag(accept), .in_service_level_flag(in_svc),
        .nmi_req(nmi), .irq_event, .wake, .pc_load, .cpu_clk_en, .main_osc_en, .timer16_run(),
        .wdt_run(), .adc_run(), .timer8_ext_only(), .watch_sub_only(), .serial_ext_clk_only(),
        .uart_freeze(), .crystal_out_pullup, .clock_out_force_low, .tone_out_force_low,
        .port_hold(), .pins_hiz, .port_latch(), .bus_stop, .upper_bus_hold());
    srrc_core_model cm (.aclk, .halt_exec, .stop_exec, .reset_pin_n, .irq_event);

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (wake.vector_go === 1'b1) nvec++;
        if (wake.resume_go === 1'b1) nres++;
        if (wake.vector_go === 1'b1 || wake.resume_go === 1'b1) nwk++;
        if (wake.reset_go === 1'b1) rst_at = cyc;
        if (wake.reset_go === 1'b1) nrst++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && s_axi_awready !== 1'b1) || (s_axi_wvalid && s_axi_wready !== 1'b1));
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wmode(input logic [2:0] m);
        int n;
        n = 0;
        do begin
            axr(SRRC_OFF_STATUS, rd, rs);
            n++;
        end while (rd[2:0] !== m && n < 400);
        chk(rd[2:0], m);
    endtask
    task automatic wait_wake(ref int c, input int lim, output int n);
        int b;
        b = c;
        n = 0;
        while (c == b && n < lim) begin
            @(posedge aclk);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(pins_hiz, 1'b1);
        axr(SRRC_OFF_SETTLE, rd, rs);
        chk(rd, 32'h4);
        axr(SRRC_OFF_CTRL, rd, rs);
        chk(rd, 32'hffff);
        axr(SRRC_OFF_IRQ, rd, rs);
        chk(rd, 32'h0);
        axr(SRRC_OFF_PORT, rd, rs);
        chk(rd, 32'h0);
        axr(8'h40, rd, rs);
        chk(rs, SRRC_RESP_SLVERR);
        axw(SRRC_OFF_STATUS, 32'h0, rs);
        chk(rs, SRRC_RESP_SLVERR);
        wmode(3'd2);
        chk(rd[15:8], SRRC_RST_STATUS_WORD);
        chk(pins_hiz, 1'b0);
        chk((rst_at - t0) inside {[511:520]}, 1'b1);
    endtask
    task automatic t_standby(input logic st);
        int n, bv, br;
        logic [5:0] e;
        axw(SRRC_OFF_SETTLE, 32'h0, rs);
        for (int i = 0; i < 6; i++) begin
            e = TBL[i];
            axw(SRRC_OFF_CTRL, {16'h0, {8{e[4]}}, {8{e[5]}}}, rs);
            accept <= e[3];
            in_svc <= e[2];
            cm.pulse(int'(st), 8'h00);
            wmode(st ? 3'd4 : 3'd3);
            if (st) chk({crystal_out_pullup, clock_out_force_low, tone_out_force_low, bus_stop, main_osc_en, cpu_clk_en}, 10'b1111011100);
            bv = nvec;
            br = nres;
            cm.pulse(2, 8'h01);
            wait_wake(nwk, 300, n);
            if (e[1]) begin
                wmode(st ? 3'd4 : 3'd3);
                axw(SRRC_OFF_IRQ, 32'hff, rs);
                if (st) begin
                    cm.pin_reset();
                    wait_wake(nrst, 2000, n);
                    wmode(3'd2);
                end else begin
                    accept <= 1'b0;
                    nmi <= 1'b1;
                    wait_wake(nvec, 100, n);
                    nmi <= 1'b0;
                    chk(nvec - bv, 1);
                end
            end else begin
                chk(nvec - bv, e[0]);
                chk(nres - br, !e[0]);
                if (st) chk(n >= 16, 1'b1);
                axw(SRRC_OFF_IRQ, 32'hff, rs);
            end
        end
    endtask
    task automatic t_misc();
        int b, n;
        on_sub <= 1'b1;
        cm.pulse(1, 8'h00);
        wmode(3'd2);
        on_sub <= 1'b0;
        b = nrst;
        wdt_ov <= 1'b1;
        @(posedge aclk);
        wdt_ov <= 1'b0;
        wait_wake(nrst, 2000, n);
        chk(nrst, b + 1);
        chk(pc_load, SRRC_RESET_VECTOR);
        axw(SRRC_OFF_CTRL, 32'h0, rs);
        cm.pulse(2, 8'h02);
        b = nwk;
        cm.pulse(1, 8'h00);
        wait_wake(nwk, 1000, n);
        chk(nwk, b + 1);
        axw(SRRC_OFF_IRQ, 32'hff, rs);
        cm.pulse(0, 8'h00);
        wmode(3'd3);
        b = nrst;
        cm.pin_reset();
        chk(pins_hiz, 1'b1);
        wait_wake(nrst, 2000, n);
        chk(nrst, b + 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t0 = cyc;
        t_reset();
        t_standby(1'b0);
        t_standby(1'b1);
        t_misc();
        print_verdict();
    end
    initial begin
        #1_000_000;
        num_errors++;
        print_verdict();
    end
endmodule // test_standby_release_and_reset_control
